// ==== dbc_decoder.sv ====
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`include "dbc_params.svh"
module dbc_decoder (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             resetn_i,
  // AXI4-Lite write address and data
  input  wire logic [7:0]       s_axi_awaddr_i,
  input  wire logic             s_axi_awvalid_i,
  output logic                  s_axi_awready_o,
  input  wire logic [31:0]      s_axi_wdata_i,
  input  wire logic [3:0]       s_axi_wstrb_i,
  input  wire logic             s_axi_wvalid_i,
  output logic                  s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]            s_axi_bresp_o,
  output logic                  s_axi_bvalid_o,
  input  wire logic             s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [7:0]       s_axi_araddr_i,
  input  wire logic             s_axi_arvalid_i,
  output logic                  s_axi_arready_o,
  output logic [31:0]           s_axi_rdata_o,
  output logic [1:0]            s_axi_rresp_o,
  output logic                  s_axi_rvalid_o,
  input  wire logic             s_axi_rready_i,
  // Drive side
  input  wire dbc_pkg::dbc_din_t din_i,
  input  wire dbc_pkg::dbc_drv_t drv_i,
  output dbc_pkg::dbc_cmd_t      cmd_o
);

  logic [15:0]       cw_r;
  logic [23:0]       cfg_r;
  logic [1:0]        setup_r;
  logic [1:0]        setup_nxt;
  dbc_pkg::dbc_cmd_t cmd_r;
  dbc_pkg::dbc_cmd_t cmd_nxt;
  logic              awready_r;
  logic              wready_r;
  logic              aw_got_r;
  logic              w_got_r;
  logic [7:0]        awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;

  // Byte-lane merge helper
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // Source selection: digital input, bus, AND, OR
  function automatic logic gate(input logic [1:0] sel,
                                input logic       bus_b,
                                input logic       din_b);
    case (sel)
      `DBC_SRC_DIN: gate = din_b;
      `DBC_SRC_BUS: gate = bus_b;
      `DBC_SRC_AND: gate = bus_b & din_b;
      `DBC_SRC_OR:  gate = bus_b | din_b;
      default:      gate = din_b;
    endcase
  endfunction : gate

  // Write decode
  wire        wr_fire  = aw_got_r & w_got_r & ~bvalid_r;
  wire        wr_cmd   = wr_fire & (awaddr_r == `DBC_CMD_OFS);
  wire        wr_cfg   = wr_fire & (awaddr_r == `DBC_CFG_OFS);
  wire        wr_stat  = wr_fire & (awaddr_r == `DBC_STAT_OFS);
  wire        wr_bad   = wr_fire & ~wr_cmd & ~wr_cfg & ~wr_stat;
  wire [31:0] cw_merge = merge({16'h0000, cw_r}, wdata_r, wstrb_r);
  wire [31:0] cf_merge = merge({8'h00, cfg_r}, wdata_r, wstrb_r);
  wire        cw_acc   = wr_cmd & cw_merge[`DBC_B_VALID];
  wire        rst_edge = cw_acc & cw_merge[`DBC_B_RESET]
                         & ~cw_r[`DBC_B_RESET];

  // Configuration fields
  wire [1:0] sel_coast = cfg_r[`DBC_CF_COAST +: 2];
  wire [1:0] sel_qstop = cfg_r[`DBC_CF_QSTOP +: 2];
  wire [1:0] sel_start = cfg_r[`DBC_CF_START +: 2];
  wire [1:0] sel_setup = cfg_r[`DBC_CF_SETUP +: 2];
  wire [1:0] sel_rev   = cfg_r[`DBC_CF_REV +: 2];
  wire [5:0] relay_fn  = cfg_r[`DBC_CF_RELAY +: 6];
  wire [3:0] act_setup = cfg_r[`DBC_CF_ACT +: 4];
  wire [3:0] link_mask = cfg_r[`DBC_CF_LINK +: 4];

  // Bus bits gated with digital inputs
  wire coast_g = gate(sel_coast, cw_r[3], din_i.coast_ok);
  wire qstop_g = gate(sel_qstop, cw_r[4], din_i.qstop_ok);
  wire start_g = gate(sel_start, cw_r[6], din_i.start_ok);
  wire rev_g   = gate(sel_rev, cw_r[15], din_i.reverse);
  wire [1:0] setup_req = {gate(sel_setup, cw_r[14], din_i.setup[1]),
                          gate(sel_setup, cw_r[13], din_i.setup[0])};

  // Set-up change control
  wire multi_on  = (act_setup == `DBC_MULTI_SET);
  wire linked    = link_mask[setup_r] & link_mask[setup_req];
  wire setup_ok  = multi_on & (~drv_i.running | linked);
  assign setup_nxt = setup_ok ? setup_req : setup_r;

  // Stop conditions; ramp time choice is the ramp generator's job
  wire ramp_stop  = ~cw_r[0] | ~start_g;
  wire coast_stop = ~cw_r[1] | ~coast_g;
  wire quick_stop = ~cw_r[2] | ~qstop_g;
  wire any_stop   = ramp_stop | coast_stop | quick_stop;
  wire relay_on   = (relay_fn == `DBC_RELAY_ZERO) & drv_i.freq_zero
                    & any_stop;
  wire jog_ok     = ~cw_r[4] & (&cw_r[3:0]);

  always_comb begin
    cmd_nxt            = '0;
    cmd_nxt.ramp_stop  = ramp_stop;
    cmd_nxt.coast_stop = coast_stop;
    cmd_nxt.quick_stop = quick_stop;
    cmd_nxt.hold_freq  = ~cw_r[5];
    cmd_nxt.start_ok   = coast_g & qstop_g & start_g & ~drv_i.trip;
    cmd_nxt.trip_reset = rst_edge;
    cmd_nxt.jog1       = cw_r[`DBC_B_JOG1] & jog_ok;
    cmd_nxt.jog2       = cw_r[`DBC_B_JOG2] & jog_ok;
    cmd_nxt.slow_down  = cw_r[11];
    cmd_nxt.catch_up   = cw_r[12] & ~cw_r[11];
    cmd_nxt.reverse    = rev_g;
    cmd_nxt.relay_on   = relay_on;
    cmd_nxt.sw_inhibit = cw_r[0] | cw_r[2];
    cmd_nxt.setup      = setup_nxt;
  end

  // Applied word and configuration
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cw_r    <= `DBC_CW_RST;
      cfg_r   <= `DBC_CFG_RST;
      setup_r <= 2'h0;
      cmd_r   <= '0;
    end else begin
      if (cw_acc) begin
        cw_r <= cw_merge[15:0];
      end
      if (wr_cfg) begin
        cfg_r <= cf_merge[23:0];
      end
      setup_r <= setup_nxt;
      cmd_r   <= cmd_nxt;
    end
  end

  // Write channel: address and data taken in either order
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && awready_r) begin
        awready_r <= 1'b0;
        aw_got_r  <= 1'b1;
        awaddr_r  <= {s_axi_awaddr_i[7:2], 2'b00};
      end else if (!aw_got_r && !bvalid_r) begin
        awready_r <= 1'b1;
      end
      if (s_axi_wvalid_i && wready_r) begin
        wready_r <= 1'b0;
        w_got_r  <= 1'b1;
        wdata_r  <= s_axi_wdata_i;
        wstrb_r  <= s_axi_wstrb_i;
      end else if (!w_got_r && !bvalid_r) begin
        wready_r <= 1'b1;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
      end
    end
  end

  // Write response; status register ignores writes
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `DBC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_bad ? `DBC_RESP_SLV : `DBC_RESP_OKAY;
    end else if (s_axi_bready_i) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read decode
  wire [7:0]  rd_addr = {s_axi_araddr_i[7:2], 2'b00};
  wire        rd_cmd  = (rd_addr == `DBC_CMD_OFS);
  wire        rd_cfg  = (rd_addr == `DBC_CFG_OFS);
  wire        rd_stat = (rd_addr == `DBC_STAT_OFS);
  wire [31:0] rd_mux  = rd_cmd  ? {16'h0000, cw_r} :
                        rd_cfg  ? {8'h00, cfg_r} :
                        rd_stat ? {17'h00000, cmd_r} : 32'h0000_0000;
  wire        rd_bad  = ~rd_cmd & ~rd_cfg & ~rd_stat;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `DBC_RESP_OKAY;
    end else if (s_axi_arvalid_i && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_mux;
      rresp_r   <= rd_bad ? `DBC_RESP_SLV : `DBC_RESP_OKAY;
    end else if (rvalid_r) begin
      if (s_axi_rready_i) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end else begin
      arready_r <= 1'b1;
    end
  end

  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o  = wready_r;
  assign s_axi_bvalid_o  = bvalid_r;
  assign s_axi_bresp_o   = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o  = rvalid_r;
  assign s_axi_rdata_o   = rdata_r;
  assign s_axi_rresp_o   = rresp_r;
  assign cmd_o           = cmd_r;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  chk_invalid_ignored: assert property (
    (wr_cmd && !cw_merge[`DBC_B_VALID]) |=> $stable(cw_r))
    else $error("Word without valid bit changed applied word");

  chk_reset_edge: assert property (
    rst_edge |=> cmd_r.trip_reset ##1 !cmd_r.trip_reset)
    else $error("Reset edge did not give a single pulse");

  chk_reset_cause: assert property (
    cmd_r.trip_reset |-> $past(cw_acc) && $past(!cw_r[`DBC_B_RESET]))
    else $error("Trip reset without rising edge of reset bit");

  chk_jog_gating: assert property (
    (cmd_r.jog1 || cmd_r.jog2) |-> $past(!cw_r[4] && (&cw_r[3:0])))
    else $error("Jog active outside its permitted bit pattern");

  chk_slow_prio: assert property (
    $past(cw_r[11] && cw_r[12]) |-> cmd_r.slow_down && !cmd_r.catch_up)
    else $error("Catch-up not overridden by slow-down");

  chk_start_trip: assert property (
    drv_i.trip |=> !cmd_r.start_ok)
    else $error("Start permitted while trip pending");

  chk_setup_gate: assert property (
    (setup_r != $past(setup_r)) |-> $past(multi_on)
      && ($past(!drv_i.running) || $past(linked)))
    else $error("Set-up changed without multi set-up or link");

  chk_rev_source: assert property (
    resetn_i && (sel_rev == `DBC_SRC_DIN)
      |=> cmd_r.reverse == $past(din_i.reverse))
    else $error("Reverse not following digital input");

  chk_bresp_timing: assert property (
    (wr_fire && !wr_bad) |=> s_axi_bvalid_o && s_axi_bresp_o == 2'h0)
    else $error("Write response late or wrong");

  // Edge after release still shows reset values in cmd_r, so the
  // per-cycle output checks wait for a live reset in the antecedent

  chk_ramp_stop: assert property (
    resetn_i && !cw_r[0] |=> cmd_r.ramp_stop)
    else $error("Bit 00 low without ramp stop");

  chk_coast_stop: assert property (
    resetn_i && !cw_r[1] |=> cmd_r.coast_stop)
    else $error("Bit 01 low without coasting stop");

  chk_quick_stop: assert property (
    resetn_i && !cw_r[2] |=> cmd_r.quick_stop)
    else $error("Bit 02 low without quick stop");

  chk_inhibit_state: assert property (
    resetn_i |=> cmd_r.sw_inhibit == $past(cw_r[0] || cw_r[2]))
    else $error("Switching-on-inhibited state wrong");

  chk_coast_gate: assert property (
    resetn_i && !coast_g |=> cmd_r.coast_stop && !cmd_r.start_ok)
    else $error("Gated coast low did not stop");

  chk_qstop_gate: assert property (
    resetn_i && !qstop_g |=> cmd_r.quick_stop && !cmd_r.start_ok)
    else $error("Gated quick stop low did not stop");

  chk_hold_freq: assert property (
    resetn_i |=> cmd_r.hold_freq == $past(!cw_r[5]))
    else $error("Hold frequency does not follow bit 05");

  chk_start_gate: assert property (
    resetn_i && !start_g |=> cmd_r.ramp_stop && !cmd_r.start_ok)
    else $error("Gated start low did not ramp stop");

  chk_trip_single: assert property (
    cmd_r.trip_reset |=> !cmd_r.trip_reset)
    else $error("Trip reset pulse longer than one cycle");

  chk_word_applied: assert property (
    cw_acc |=> cw_r == $past(cw_merge[15:0]))
    else $error("Valid word not applied");

  chk_slow_down: assert property (
    resetn_i |=> cmd_r.slow_down == $past(cw_r[11]))
    else $error("Slow-down does not follow bit 11");

  chk_catch_up: assert property (
    resetn_i && cw_r[12] && !cw_r[11] |=> cmd_r.catch_up)
    else $error("Catch-up missing with bit 12 alone");

  chk_setup_order: assert property (
    resetn_i && multi_on && !drv_i.running
      && (sel_setup == `DBC_SRC_BUS) |=> setup_r == $past(cw_r[14:13]))
    else $error("Bus set-up bits mapped wrongly");

  chk_setup_out: assert property (
    resetn_i |=> cmd_r.setup == setup_r)
    else $error("Set-up output differs from held set-up");

  chk_setup_hold: assert property (
    !multi_on |=> $stable(setup_r))
    else $error("Set-up moved without multi set-up option");

  chk_rev_bus: assert property (
    resetn_i && (sel_rev == `DBC_SRC_BUS)
      |=> cmd_r.reverse == $past(cw_r[15]))
    else $error("Bus reverse not following bit 15");

  chk_rev_and: assert property (
    resetn_i && (sel_rev == `DBC_SRC_AND)
      |=> cmd_r.reverse == $past(cw_r[15] && din_i.reverse))
    else $error("Reverse not gated by logic AND");

  chk_relay_zero: assert property (
    !drv_i.freq_zero || (relay_fn != `DBC_RELAY_ZERO) |=> !cmd_r.relay_on)
    else $error("Relay on away from 0 Hz or its option");

  chk_relay_stop: assert property (
    resetn_i && drv_i.freq_zero && (relay_fn == `DBC_RELAY_ZERO)
      && !cw_r[0] |=> cmd_r.relay_on)
    else $error("Relay off at 0 Hz during ramp stop");

  chk_start_ok: assert property (
    resetn_i && coast_g && qstop_g && start_g && !drv_i.trip
      |=> cmd_r.start_ok)
    else $error("Start not permitted with all permits");

  chk_wr_refused: assert property (
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("Write channel ready while response pending");

  chk_rd_single: assert property (
    s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("Read address ready while data pending");

  cov_trip_reset: cover property (rst_edge ##1 cmd_r.trip_reset);
  cov_jog1:       cover property (cmd_r.jog1);
  cov_setup_move: cover property (setup_r != $past(setup_r));
  cov_bus_rev:    cover property (sel_rev == `DBC_SRC_BUS && cmd_r.reverse);
  cov_ignored_word: cover property (wr_cmd && !cw_merge[`DBC_B_VALID]);

endmodule : dbc_decoder

// ==== dbc_params.svh ====
`ifndef DBC_PARAMS_SVH
`define DBC_PARAMS_SVH
`define DBC_CMD_OFS    8'h00
`define DBC_CFG_OFS    8'h04
`define DBC_STAT_OFS   8'h08
`define DBC_CW_RST     16'h0000
`define DBC_CFG_RST    24'h000000
`define DBC_B_JOG1     8
`define DBC_B_JOG2     9
`define DBC_B_VALID    10
`define DBC_B_RESET    7
`define DBC_CF_COAST   0
`define DBC_CF_QSTOP   2
`define DBC_CF_START   4
`define DBC_CF_SETUP   6
`define DBC_CF_REV     8
`define DBC_CF_RELAY   10
`define DBC_CF_ACT     16
`define DBC_CF_LINK    20
`define DBC_SRC_DIN    2'h0
`define DBC_SRC_BUS    2'h1
`define DBC_SRC_AND    2'h2
`define DBC_SRC_OR     2'h3
`define DBC_RELAY_ZERO 6'h1F
`define DBC_MULTI_SET  4'h9
`define DBC_RESP_OKAY  2'h0
`define DBC_RESP_SLV   2'h2
`endif

// ==== dbc_pkg.sv ====
package dbc_pkg;
  typedef struct packed {
    logic       coast_ok;
    logic       qstop_ok;
    logic       start_ok;
    logic       reverse;
    logic [1:0] setup;
  } dbc_din_t;

  typedef struct packed {
    logic trip;
    logic freq_zero;
    logic running;
  } dbc_drv_t;

  typedef struct packed {
    logic       ramp_stop;
    logic       coast_stop;
    logic       quick_stop;
    logic       hold_freq;
    logic       start_ok;
    logic       trip_reset;
    logic       jog1;
    logic       jog2;
    logic       slow_down;
    logic       catch_up;
    logic       reverse;
    logic       relay_on;
    logic       sw_inhibit;
    logic [1:0] setup;
  } dbc_cmd_t;
endpackage : dbc_pkg

// ==== dbc_axi_master.sv ====
module dbc_axi_master (
  // Clock
  input  wire logic        sys_clk_i,
  // Write channels
  output logic [7:0]       awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [31:0]      wdata_o,
  output logic [3:0]       wstrb_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  // Read channels
  output logic [7:0]       araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    awaddr_o = 8'h00;
    awvalid_o = 1'b0;
    wdata_o = 32'h0000_0000;
    wstrb_o = 4'hF;
    wvalid_o = 1'b0;
    bready_o = 1'b0;
    araddr_o = 8'h00;
    arvalid_o = 1'b0;
    rready_o = 1'b0;
  end

  // Released payload is scrambled so nothing relies on stale values
  task automatic wr(input logic [7:0]  a,
                    input logic [31:0] d,
                    input logic [3:0]  s = 4'hF);
    awaddr_o <= a;
    wdata_o <= d;
    wstrb_o <= s;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    fork
      begin
        do @(posedge sys_clk_i); while (!awready_i);
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
      end
      begin
        do @(posedge sys_clk_i); while (!wready_i);
        wvalid_o <= 1'b0;
        wdata_o <= ~d;
        wstrb_o <= ~s;
      end
    join
    do @(posedge sys_clk_i); while (!bvalid_i);
    bready_o <= 1'b0;
    // Idle edge so a next call never re-raises bready in the same step
    @(posedge sys_clk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    do @(posedge sys_clk_i); while (!arready_i);
    arvalid_o <= 1'b0;
    araddr_o <= ~a;
    do @(posedge sys_clk_i); while (!rvalid_i);
    rready_o <= 1'b0;
    // Idle edge so a next call never re-raises rready in the same step
    @(posedge sys_clk_i);
  endtask : rd
endmodule : dbc_axi_master

// ==== dbc_decoder_tb_top.sv ====
`include "dbc_params.svh"
module dbc_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic              sys_clk, resetn, awvalid, awready, wvalid, wready;
  logic              bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]        awaddr, araddr;
  logic [31:0]       wdata, rdata, rnd;
  logic [1:0]        bresp, rresp, su;
  dbc_pkg::dbc_din_t din;
  dbc_pkg::dbc_drv_t drv;
  dbc_pkg::dbc_cmd_t cmd;
  logic [15:0]       w;
  logic [23:0]       cf;
  logic              p7;
  logic              sr;
  logic [3:0]        wstrb;
  logic [33:0]       e;
  logic [33:0]       q[$];
  int                pe, ps, err_total, check_count;

  dbc_decoder dbc_decoder_inst (.sys_clk_i(sys_clk), .resetn_i(resetn),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .din_i(din), .drv_i(drv), .cmd_o(cmd));

  dbc_axi_master dbc_axi_master_inst (.sys_clk_i(sys_clk),
    .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
    .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
    .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
    .arvalid_o(arvalid), .arready_i(arready), .rvalid_i(rvalid),
    .rready_o(rready));

  function automatic logic [31:0] lf(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lf

  function automatic logic g(input logic [1:0] s, input logic b, d);
    return (s == 2'h0) ? d : (s == 2'h1) ? b : (s == 2'h2) ? (b & d) : (b | d);
  endfunction : g

  function automatic logic [31:0] ex();
    logic c, k, s, rs, cs, qs;
    c = g(cf[1:0], w[3], din.coast_ok);
    k = g(cf[3:2], w[4], din.qstop_ok);
    s = g(cf[5:4], w[6], din.start_ok);
    rs = !w[0] | !s;
    cs = !w[1] | !c;
    qs = !w[2] | !k;
    return {17'h0, rs, cs, qs, !w[5], c & k & s & !drv.trip, 1'b0,
      w[8] & !w[4] & (&w[3:0]), w[9] & !w[4] & (&w[3:0]), w[11],
      w[12] & !w[11], g(cf[9:8], w[15], din.reverse),
      cf[15:10] == 6'h1F && drv.freq_zero && (rs | cs | qs), w[0] | w[2],
      su};
  endfunction : ex

  task automatic supd();
    logic [1:0] n;
    n = {g(cf[7:6], w[14], din.setup[1]), g(cf[7:6], w[13], din.setup[0])};
    if (cf[19:16] == 4'h9 && (!drv.running || (cf[20+su] && cf[20+n])))
      su = n;
  endtask : supd

  task automatic check(input logic [33:0] got, exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask : check

  task automatic step(input logic [23:0] c, input logic [15:0] v,
                      input logic [5:0] d, input logic [2:0] r);
    din <= d;
    drv <= r;
    @(posedge sys_clk);
    supd();
    q.push_back(34'h0);
    dbc_axi_master_inst.wr(`DBC_CFG_OFS, {8'h00, c});
    cf = c;
    supd();
    q.push_back({10'h0, c});
    dbc_axi_master_inst.rd(`DBC_CFG_OFS);
    q.push_back(34'h0);
    dbc_axi_master_inst.wr(`DBC_CMD_OFS, {16'h0, v});
    if (v[10]) begin
      pe += int'(v[7] & !p7);
      p7 = v[7];
      w = v;
    end
    supd();
    repeat (3) @(posedge sys_clk);
    q.push_back({2'h0, ex()});
    sr = 1'b1;
    dbc_axi_master_inst.rd(`DBC_STAT_OFS);
    sr = 1'b0;
    $display("step done cfg=%h word=%h", c, v);
  endtask : step

  task automatic conclude();
    check({2'h0, 32'(ps)}, {2'h0, 32'(pe)});
    $display("checks=%0d mismatches=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // Monitor: each completed response retires the oldest note
  always @(posedge sys_clk) begin
    if (bvalid === 1'b1 && bready === 1'b1)
      check({bresp, 32'h0}, q.pop_front());
    if (rvalid === 1'b1 && rready === 1'b1) begin
      e = q.pop_front();
      check({rresp, rdata}, e);
      if (sr === 1'b1)
        check({19'h0, cmd}, e);
    end
    if (cmd.trip_reset === 1'b1)
      ps++;
  end

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    err_total++;
    conclude();
  end

  initial begin
    resetn = 1'b0;
    din = 6'h3F;
    drv = 3'h0;
    w = 16'h0;
    cf = 24'h0;
    su = 2'h0;
    p7 = 1'b0;
    rnd = 32'h6;
    repeat (12) @(posedge sys_clk);
    sr = 1'b0;
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    q.push_back({2'h0, ex()});
    sr = 1'b1;
    dbc_axi_master_inst.rd(`DBC_STAT_OFS);
    sr = 1'b0;
    q.push_back({2'h2, 32'h0});
    dbc_axi_master_inst.rd(8'h0C);
    q.push_back({2'h2, 32'h0});
    dbc_axi_master_inst.wr(8'h0C, 32'hFFFF_FFFF);
    q.push_back(34'h0);
    dbc_axi_master_inst.wr(`DBC_STAT_OFS, 32'hFFFF_FFFF);
    // Only byte lane 1 of the configuration may change
    q.push_back(34'h0);
    dbc_axi_master_inst.wr(`DBC_CFG_OFS, 32'hFFFF_FFFF, 4'h2);
    cf = 24'h00FF00;
    q.push_back({10'h0, cf});
    dbc_axi_master_inst.rd(`DBC_CFG_OFS);
    // Bus sources, then jogs, edge reset, ignored word, set-up moves
    step(24'h097D55, 16'h047F, 6'h00, 3'h0);
    step(24'h097D55, 16'h070F, 6'h00, 3'h0);
    step(24'h097D55, 16'h1C8F, 6'h00, 3'h0);
    step(24'h097D55, 16'h0080, 6'h00, 3'h2);
    step(24'h097D55, 16'hE400, 6'h00, 3'h2);
    step(24'h397D55, 16'h2400, 6'h00, 3'h1);
    step(24'h397D55, 16'h0400, 6'h00, 3'h0);
    step(24'h397D55, 16'h2400, 6'h00, 3'h1);
    step(24'h007D55, 16'h6400, 6'h00, 3'h0);
    step(24'h007EAA, 16'hFFFF, 6'h15, 3'h4);
    step(24'h007FFF, 16'hFFFF, 6'h15, 3'h4);
    for (int i = 0; i < 16; i++) begin
      rnd = lf(rnd);
      step(rnd[23:0], 16'(lf(rnd) >> 16), rnd[29:24], rnd[31:29]);
    end
    conclude();
  end
endmodule : dbc_decoder_tb_top
